// File: inc/ddrcs_regs.svh
// register offsets, fields, reset values and timing counts of the command state block
`ifndef DDRCS_REGS_SVH
`define DDRCS_REGS_SVH
`define DDRCS_ADDR_W         15
`define DDRCS_BANK_W         2
`define DDRCS_BA_REGULAR     2'h0
`define DDRCS_BA_EXTENDED    2'h1
`define DDRCS_EXT_DLL_BIT    0
`define DDRCS_EXT_DRV_LO_BIT 1
`define DDRCS_EXT_DRV_HI_BIT 6
`define DDRCS_MODE_TEST_BIT  7
`define DDRCS_EXT_RESET      15'h0000
`define DDRCS_MODE_RESET     15'h0000
`define DDRCS_REFC_CYC       15
`define DDRCS_RSC_CYC        2
`define DDRCS_POWERDOWN_EXIT_CYC       2
`define DDRCS_FPDL_MIN_CYC   1
`define DDRCS_FPDL_MAX_CYC   3
`define DDRCS_BURST_CYC      4
`endif

// File: inc/ddrcs_pkg.sv
// types of the command state block
package ddrcs_pkg;
  typedef enum logic [7:0] {
    DDRCS_IDLE     = 8'h01,
    DDRCS_ACT_RD   = 8'h02,
    DDRCS_ACT_WR   = 8'h04,
    DDRCS_READ     = 8'h08,
    DDRCS_WRITE    = 8'h10,
    DDRCS_AREF     = 8'h20,
    DDRCS_MODE_ACC = 8'h40,
    DDRCS_PWRDN    = 8'h80
  } ddrcs_state_t;
  typedef enum logic [1:0] {
    DDRCS_DRV_NORMAL  = 2'h0,
    DDRCS_DRV_STRONG  = 2'h1,
    DDRCS_DRV_WEAKER  = 2'h2,
    DDRCS_DRV_WEAKEST = 2'h3
  } ddrcs_drive_t;
endpackage : ddrcs_pkg

// File: inc/ddrcs_timer_if.sv
// load and expiry signals between the state machine and its wait counter
`timescale 1ns/1ps
interface ddrcs_timer_if;
  logic       load;
  logic [4:0] count;
  logic       done;
  modport ctrl (output load, output count, input done);
  modport tmr  (input load, input count, output done);
endinterface : ddrcs_timer_if

// File: rtl/ddrcs_timer.sv
// down counter for recovery, lockout and burst waits
`timescale 1ns/1ps
module ddrcs_timer (
  input  wire logic     core_clk_in,
  input  wire logic     rst_n_in,
  ddrcs_timer_if.tmr    tif
);
  logic [4:0] cnt_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_r <= 5'h00;
    else if (tif.load)
      cnt_r <= tif.count;
    else if (cnt_r != 5'h00)
      cnt_r <= cnt_r - 5'h01;
  end
  // expiry ignores load, so the caller's decode never loops back on itself
  assign tif.done = (cnt_r == 5'h01);
endmodule : ddrcs_timer

// File: rtl/ddrcs_cmd_state.sv
// command state machine with pin sampling and mode register capture
`timescale 1ns/1ps
`include "ddrcs_regs.svh"
// Contract
// - idle, cs low, fn high: read activate
// - idle, cs low, fn low: write activate
// - after read activate: latch or mode set
// - deselects let read burst finish
// - deselects let write burst finish
// - refresh plus pd low in window: self-refresh
// - pd low held: stay powered down
// - pd exit with cs high, idle after recovery
// - pd low with the refresh command: self-refresh
// - bank bits zero: regular mode register
// - bank 01: extended register, drive field
module ddrcs_cmd_state #(
  parameter int ADDR_W = `DDRCS_ADDR_W
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      chip_select_n_in,
  input  wire logic                      function_select_in,
  input  wire logic [`DDRCS_BANK_W-1:0]  bank_in,
  input  wire logic [ADDR_W-1:0]         addr_in,
  input  wire logic                      power_down_n_in,
  output logic [7:0]                     state_out,
  output logic [`DDRCS_BANK_W-1:0]       bank_out,
  output logic [ADDR_W-1:0]              upper_address_out,
  output logic [ADDR_W-1:0]              lower_address_out,
  output logic                           burst_read_out,
  output logic                           burst_write_out,
  output logic                           self_refresh_out,
  output logic [ADDR_W-1:0]              mode_reg_out,
  output logic [ADDR_W-1:0]              extended_mode_config_out,
  output ddrcs_pkg::ddrcs_drive_t        drive_strength_field_out,
  output logic                           dll_switch_out,
  output logic                           illegal_cmd_out
);
  if (ADDR_W != `DDRCS_ADDR_W)
  begin : g_bad_addr_w
    $error("ddrcs_cmd_state: address width must match pin count");
  end

  // pins are launched on this clock; a two-of-three filter would swallow
  // one-cycle commands, so they are decoded at the sampling edge itself
  logic                     pd_prev_r;
  wire                      cs_n_q = chip_select_n_in;
  wire                      fn_q   = function_select_in;
  wire                      pd_q   = power_down_n_in;
  wire  [`DDRCS_BANK_W-1:0] ba_q   = bank_in;
  wire  [ADDR_W-1:0]        ad_q   = addr_in;

  ddrcs_pkg::ddrcs_state_t state_r, state_nxt;
  logic self_r, self_nxt;
  logic [4:0] since_ref_r;
  logic [`DDRCS_BANK_W-1:0] bank_r;
  logic [ADDR_W-1:0] ua_r, la_r, mode_r, ext_r;
  logic illegal_nxt;

  ddrcs_timer_if tif ();
  ddrcs_timer u_timer (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .tif         (tif)
  );

  // pin decodes
  wire pd_hh    = pd_prev_r && pd_q;
  wire pd_hl    = pd_prev_r && !pd_q;
  wire pd_lh    = !pd_prev_r && pd_q;
  wire pd_ll    = !pd_prev_r && !pd_q;
  wire desel    = pd_hh && cs_n_q;
  wire sel_any  = pd_hh && !cs_n_q;
  wire pd_entry = pd_hl && cs_n_q;
  wire pd_leave = pd_lh && cs_n_q;
  wire ref_win  = (since_ref_r >= 5'(`DDRCS_FPDL_MIN_CYC)) && (since_ref_r <= 5'(`DDRCS_FPDL_MAX_CYC));
  wire ba_reg   = (ba_q == `DDRCS_BA_REGULAR);
  wire ba_ext   = (ba_q == `DDRCS_BA_EXTENDED);
  wire mode_wr  = (state_r == ddrcs_pkg::DDRCS_ACT_RD) && sel_any;

  always_comb
  begin
    state_nxt   = state_r;
    self_nxt    = self_r;
    illegal_nxt = 1'b0;
    tif.load    = 1'b0;
    tif.count   = 5'h00;
    case (state_r)
      ddrcs_pkg::DDRCS_IDLE:
      begin
        if (sel_any && fn_q)
          state_nxt = ddrcs_pkg::DDRCS_ACT_RD;
        else if (sel_any)
          state_nxt = ddrcs_pkg::DDRCS_ACT_WR;
        else if (pd_entry)
        begin
          state_nxt = ddrcs_pkg::DDRCS_PWRDN;
          self_nxt  = 1'b0;
        end
        else if (pd_hl)
          illegal_nxt = 1'b1;
      end
      ddrcs_pkg::DDRCS_ACT_RD:
      begin
        // second command is always the very next clock
        if (desel)
        begin
          state_nxt = ddrcs_pkg::DDRCS_READ;
          tif.load  = 1'b1;
          tif.count = 5'(`DDRCS_BURST_CYC);
        end
        else if (sel_any)
        begin
          state_nxt = ddrcs_pkg::DDRCS_MODE_ACC;
          tif.load  = 1'b1;
          tif.count = 5'(`DDRCS_RSC_CYC);
        end
        else
        begin
          state_nxt   = ddrcs_pkg::DDRCS_IDLE;
          illegal_nxt = 1'b1;
        end
      end
      ddrcs_pkg::DDRCS_ACT_WR:
      begin
        if (desel)
        begin
          state_nxt = ddrcs_pkg::DDRCS_WRITE;
          tif.load  = 1'b1;
          tif.count = 5'(`DDRCS_BURST_CYC);
        end
        else if (sel_any || (pd_hl && !cs_n_q))
        begin
          state_nxt = ddrcs_pkg::DDRCS_AREF;
          self_nxt  = pd_hl;
          tif.load  = 1'b1;
          tif.count = 5'(`DDRCS_REFC_CYC);
        end
        else
        begin
          state_nxt   = ddrcs_pkg::DDRCS_IDLE;
          illegal_nxt = 1'b1;
        end
      end
      ddrcs_pkg::DDRCS_READ, ddrcs_pkg::DDRCS_WRITE:
      begin
        // other-bank activations are tolerated; the burst is not cut
        if (!pd_hh)
          illegal_nxt = 1'b1;
        if (tif.done)
          state_nxt = ddrcs_pkg::DDRCS_IDLE;
      end
      ddrcs_pkg::DDRCS_AREF:
      begin
        if (pd_entry && ref_win)
          self_nxt = 1'b1;
        else if (pd_entry || sel_any || (pd_hl && !cs_n_q))
          illegal_nxt = 1'b1;
        if (self_nxt && (pd_ll || pd_hl))
        begin
          state_nxt = ddrcs_pkg::DDRCS_PWRDN;
        end
        else if (tif.done)
          state_nxt = ddrcs_pkg::DDRCS_IDLE;
      end
      ddrcs_pkg::DDRCS_MODE_ACC:
      begin
        if (!desel)
          illegal_nxt = 1'b1;
        if (tif.done)
          state_nxt = ddrcs_pkg::DDRCS_IDLE;
      end
      ddrcs_pkg::DDRCS_PWRDN:
      begin
        if (pd_leave)
        begin
          state_nxt = ddrcs_pkg::DDRCS_MODE_ACC;
          tif.load  = 1'b1;
          tif.count = self_r ? 5'(`DDRCS_REFC_CYC) : 5'(`DDRCS_POWERDOWN_EXIT_CYC);
          self_nxt  = 1'b0;
        end
        else if (pd_lh)
          illegal_nxt = 1'b1;
        // otherwise held low: stay
      end
      default:
        state_nxt = ddrcs_pkg::DDRCS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r     <= ddrcs_pkg::DDRCS_IDLE;
      self_r      <= 1'b0;
      pd_prev_r   <= 1'b0;
      since_ref_r <= 5'h1F;
      illegal_cmd_out <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      self_r      <= self_nxt;
      pd_prev_r   <= pd_q;
      // clocks elapsed since the refresh command: one at the next edge
      since_ref_r <= (state_nxt == ddrcs_pkg::DDRCS_AREF && state_r != ddrcs_pkg::DDRCS_AREF) ? 5'h01 :
                     (since_ref_r == 5'h1F ? 5'h1F : since_ref_r + 5'h01);
      illegal_cmd_out <= illegal_nxt;
    end
  end

  // bank, address and mode register capture
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bank_r <= 2'h0;
      ua_r   <= '0;
      la_r   <= '0;
      mode_r <= `DDRCS_MODE_RESET;
      ext_r  <= `DDRCS_EXT_RESET;
    end
    else
    begin
      if (state_r == ddrcs_pkg::DDRCS_IDLE && sel_any)
      begin
        bank_r <= ba_q;
        ua_r   <= ad_q;
      end
      if ((state_r == ddrcs_pkg::DDRCS_ACT_RD || state_r == ddrcs_pkg::DDRCS_ACT_WR) && desel)
        la_r <= ad_q;
      // test bit and reserved codes are the controller's duty; stored as given
      if (mode_wr && ba_reg)
        mode_r <= ad_q;
      // non-drive, non-dll bits forced to zero
      if (mode_wr && ba_ext)
      begin
        ext_r <= '0;
        ext_r[`DDRCS_EXT_DRV_HI_BIT] <= ad_q[`DDRCS_EXT_DRV_HI_BIT];
        ext_r[`DDRCS_EXT_DRV_LO_BIT] <= ad_q[`DDRCS_EXT_DRV_LO_BIT];
        ext_r[`DDRCS_EXT_DLL_BIT]    <= ad_q[`DDRCS_EXT_DLL_BIT];
      end
    end
  end

  assign state_out                = state_r;
  assign bank_out                 = bank_r;
  assign upper_address_out        = ua_r;
  assign lower_address_out        = la_r;
  assign burst_read_out           = (state_r == ddrcs_pkg::DDRCS_READ);
  assign burst_write_out          = (state_r == ddrcs_pkg::DDRCS_WRITE);
  assign self_refresh_out         = self_r;
  assign mode_reg_out             = mode_r;
  assign extended_mode_config_out = ext_r;
  assign drive_strength_field_out = ddrcs_pkg::ddrcs_drive_t'({ext_r[`DDRCS_EXT_DRV_HI_BIT],
                                                               ext_r[`DDRCS_EXT_DRV_LO_BIT]});
  assign dll_switch_out           = ext_r[`DDRCS_EXT_DLL_BIT];

  a_rd_activate: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_IDLE && sel_any && fn_q) |=> state_r == ddrcs_pkg::DDRCS_ACT_RD)
    else $error("read activate not taken");
  a_wr_activate: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_IDLE && sel_any && !fn_q) |=> state_r == ddrcs_pkg::DDRCS_ACT_WR)
    else $error("write activate not taken");
  a_mode_select: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (mode_wr && ba_reg) |=> (mode_r == $past(ad_q) && state_r == ddrcs_pkg::DDRCS_MODE_ACC))
    else $error("mode register not written");
  a_read_burst: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_ACT_RD && desel) |=> burst_read_out [*4] ##1 !burst_read_out)
    else $error("read burst length wrong");
  a_write_burst: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_ACT_WR && desel) |=> burst_write_out [*4] ##1 !burst_write_out)
    else $error("write burst length wrong");
  a_pd_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_PWRDN && pd_ll) |=> state_r == ddrcs_pkg::DDRCS_PWRDN)
    else $error("power-down not held");
  a_pd_exit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_PWRDN && pd_leave && !self_r) |=> ##2 state_r == ddrcs_pkg::DDRCS_IDLE)
    else $error("power-down exit timing wrong");
  a_self_exit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_PWRDN && pd_leave && self_r) |=> ##15 state_r == ddrcs_pkg::DDRCS_IDLE)
    else $error("self-refresh lockout wrong");
  a_ext_field: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (mode_wr && ba_ext) |=> (drive_strength_field_out == {$past(ad_q[6]), $past(ad_q[1])}
                             && ext_r[5:2] == 4'h0))
    else $error("drive strength not captured");
  a_self_entry: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == ddrcs_pkg::DDRCS_AREF && pd_entry && ref_win) |=> (self_r && state_r == ddrcs_pkg::DDRCS_PWRDN))
    else $error("self-refresh entry missed");

  c_read: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) burst_read_out);
  c_write: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) burst_write_out);
  c_self: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) self_r);
  c_ext: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) mode_wr && ba_ext);
endmodule : ddrcs_cmd_state

// File: verification/ddrcs_ctrl_model.sv
// memory controller model driving two-cycle commands onto the pins
`timescale 1ns/1ps
module ddrcs_ctrl_model (
  input  wire logic        core_clk_in,
  output logic             chip_select_n_out,
  output logic             function_select_out,
  output logic [1:0]       bank_out,
  output logic [14:0]      addr_out,
  output logic             power_down_n_out
);
  initial
  begin
    chip_select_n_out   = 1'b1;
    function_select_out = 1'b0;
    bank_out            = 2'h0;
    addr_out            = 15'h0000;
    power_down_n_out    = 1'b1;
  end
  // one pin cycle, changed on the falling edge
  task automatic drive(input logic c, input logic f, input logic [1:0] b, input logic [14:0] a, input logic p);
    @(negedge core_clk_in);
    chip_select_n_out   = c;
    function_select_out = f;
    bank_out            = b;
    addr_out            = a;
    power_down_n_out    = p;
  endtask : drive
  // don't-care lines toggle, so a stale value cannot pass for a held one
  task automatic desel(input int n, input logic p);
    repeat (n) drive(1'b1, ~function_select_out, ~bank_out, ~addr_out, p);
  endtask : desel
  // activation, then the second command on the very next edge
  task automatic pair(input logic f, input logic [1:0] b, input logic [14:0] ua, input logic c2,
                      input logic [14:0] a2);
    drive(1'b0, f, b, ua, 1'b1);
    drive(c2, ~f, b, a2, 1'b1);
  endtask : pair
  // pd low one cycle after the refresh second command
  task automatic sref_entry();
    drive(1'b1, ~function_select_out, ~bank_out, ~addr_out, 1'b0);
  endtask : sref_entry
  // entry only issued from idle with all banks closed
  task automatic pd_entry();
    drive(1'b1, ~function_select_out, ~bank_out, ~addr_out, 1'b0);
  endtask : pd_entry
  // chip select stays high through the exit
  task automatic pd_exit();
    drive(1'b1, ~function_select_out, ~bank_out, ~addr_out, 1'b1);
  endtask : pd_exit
endmodule : ddrcs_ctrl_model

// File: verification/ddrcs_cmd_state_tb.sv
// self-checking bench of the command state block
`timescale 1ns/1ps
`include "ddrcs_regs.svh"
module ddrcs_cmd_state_tb;
  logic                    core_clk_in;
  logic                    rst_n_in;
  logic                    cs_n;
  logic                    fn;
  logic [1:0]              ba;
  logic [14:0]             addr;
  logic                    pd_n;
  logic [7:0]              state_out;
  logic [1:0]              bank_out;
  logic [14:0]             upper_out;
  logic [14:0]             lower_out;
  logic                    sref_out;
  logic [14:0]             mode_out;
  logic [14:0]             ext_out;
  ddrcs_pkg::ddrcs_drive_t drv_out;
  logic                    dll_out;
  logic                    ill_out;
  logic                    rd_out;
  logic                    wr_out;
  int                      n_rd;
  int                      n_wr;
  logic [7:0]              exp_q[$];
  logic [7:0]              last_st;
  logic [14:0]             u;
  logic [14:0]             l;
  logic [1:0]              b;
  int                      n_fail;
  int                      num_checks;
  int                      seed;
  int                      ill_seen;

  initial
  begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  ddrcs_ctrl_model i_ctl (.core_clk_in(core_clk_in), .chip_select_n_out(cs_n), .function_select_out(fn),
                          .bank_out(ba), .addr_out(addr), .power_down_n_out(pd_n));

  ddrcs_cmd_state i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(cs_n),
    .function_select_in(fn), .bank_in(ba), .addr_in(addr), .power_down_n_in(pd_n), .state_out(state_out),
    .bank_out(bank_out), .upper_address_out(upper_out), .lower_address_out(lower_out), .burst_read_out(rd_out),
    .burst_write_out(wr_out), .self_refresh_out(sref_out), .mode_reg_out(mode_out),
    .extended_mode_config_out(ext_out), .drive_strength_field_out(drv_out), .dll_switch_out(dll_out),
    .illegal_cmd_out(ill_out));

  task automatic report(input logic [14:0] g, input logic [14:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : report
  task automatic chk_state(input logic [7:0] e, input logic [7:0] g);
    report({7'h00, g}, {7'h00, e});
  endtask : chk_state
  task automatic chk_field(input logic [14:0] e, input logic [14:0] g);
    report(g, e);
  endtask : chk_field

  // each state change takes the oldest expected state
  always @(negedge core_clk_in)
  begin
    if (rst_n_in === 1'b1 && state_out !== last_st)
      chk_state((exp_q.size() > 0) ? exp_q.pop_front() : 8'hFF, state_out);
    last_st = state_out;
    if (ill_out === 1'b1)
      ill_seen++;
    if (rd_out === 1'b1)
      n_rd++;
    if (wr_out === 1'b1)
      n_wr++;
  end

  task automatic end_of_test();
    chk_field(15'h0001, ill_seen[14:0]);
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic wait_done(input string name);
    int k;
    k = 0;
    while ((exp_q.size() != 0 || state_out !== 8'h01) && k < 300)
    begin
      @(negedge core_clk_in);
      k++;
    end
    if (k == 300)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, state_out, 8'h01);
      end_of_test();
    end
    else
      $display("test %0s done", name);
  endtask : wait_done

  initial
  begin
    seed = 61;
    n_fail = 0;
    num_checks = 0;
    ill_seen = 0;
    n_rd = 0;
    n_wr = 0;
    last_st = 8'h01;
    rst_n_in = 1'b0;
    repeat (6) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    i_ctl.desel(8, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      b = 2'($random(seed));
      u = 15'($random(seed));
      l = 15'($random(seed));
      exp_q.push_back(i[0] ? 8'h04 : 8'h02);
      exp_q.push_back(i[0] ? 8'h10 : 8'h08);
      exp_q.push_back(8'h01);
      i_ctl.pair(~i[0], b, u, 1'b1, l);
      i_ctl.desel(2, 1'b1);
      wait_done("read write");
      chk_field({13'h0000, b}, {13'h0000, bank_out});
      chk_field(u, upper_out);
      chk_field(l, lower_out);
      chk_field(i[0] ? 15'h0000 : 15'(`DDRCS_BURST_CYC), n_rd[14:0]);
      chk_field(i[0] ? 15'(`DDRCS_BURST_CYC) : 15'h0000, n_wr[14:0]);
      n_rd = 0;
      n_wr = 0;
    end
    for (int d = 0; d < 4; d++)
    begin
      u = {8'h00, d[1], 4'h0, d[0], 1'b0};
      exp_q.push_back(8'h02);
      exp_q.push_back(8'h40);
      exp_q.push_back(8'h01);
      i_ctl.pair(1'b1, 2'h1, ~u, 1'b0, u);
      if (d == 3)
        i_ctl.pair(1'b1, b, ~u, 1'b1, u);
      i_ctl.desel(2, 1'b1);
      wait_done("extended mode");
      chk_field(u, ext_out);
      chk_field(d[14:0], {13'h0000, drv_out});
      chk_field(15'h0000, {14'h0000, dll_out});
    end
    // settle time after extended setup before normal traffic
    i_ctl.desel(200, 1'b1);
    l = {8'h00, 1'b0, 6'($random(seed))};
    exp_q.push_back(8'h02);
    exp_q.push_back(8'h40);
    exp_q.push_back(8'h01);
    i_ctl.pair(1'b1, 2'h0, ~l, 1'b0, l);
    i_ctl.desel(2, 1'b1);
    wait_done("regular mode");
    chk_field(l, mode_out);
    chk_field(u, ext_out);
    b = 2'($random(seed));
    u = 15'($random(seed));
    l = 15'($random(seed));
    exp_q.push_back(8'h04);
    exp_q.push_back(8'h20);
    exp_q.push_back(8'h01);
    i_ctl.pair(1'b0, b, u, 1'b0, l);
    i_ctl.desel(2, 1'b1);
    wait_done("refresh");
    exp_q.push_back(8'h04);
    exp_q.push_back(8'h20);
    exp_q.push_back(8'h80);
    i_ctl.pair(1'b0, ~b, ~u, 1'b0, ~l);
    i_ctl.sref_entry();
    i_ctl.desel(20, 1'b0);
    chk_field(15'h0001, {14'h0000, sref_out});
    exp_q.push_back(8'h40);
    exp_q.push_back(8'h01);
    i_ctl.pd_exit();
    i_ctl.desel(2, 1'b1);
    wait_done("self refresh");
    exp_q.push_back(8'h80);
    exp_q.push_back(8'h40);
    exp_q.push_back(8'h01);
    i_ctl.pd_entry();
    i_ctl.desel(12, 1'b0);
    chk_field(15'h0080, {7'h00, state_out});
    chk_field(15'h0000, {14'h0000, sref_out});
    i_ctl.pd_exit();
    i_ctl.desel(2, 1'b1);
    wait_done("power down");
    end_of_test();
  end
endmodule : ddrcs_cmd_state_tb
